// ===== rtl/srl_access.sv
// Security region access and lock logic behind the two-wire serial pins.
`default_nettype none
`include "srl_cfg.svh"

// Behaviour
// - 256 bytes, read-only lower, lockable upper page.
// - Bytes 0-15 hold read-only serial number.
// - Next 112 lower bytes reserved, read-only.
// - Answer only device type 1011b, matching pins.
// - No current-address reads of the region.
// - Sequential read wraps from 255 to 0.
// - Read ends on NACK plus Stop.
// - Writes only upper page, wrapping at page.
// - Protect pin or lock suppresses write cycle.
// - Zone protection ignored for region writes.
// - Nibble 0110b in write form means lock.
// - Lock needs both addresses and data byte.
// - Lock bytes acked only while unlocked.
// - Stop starts timed cycle, then lock applies.
// - Lock is permanent, region fully read-only.
// - Lock proceeds whatever the protect pin.
// - Status check acks first address if unlocked.
// - Delivered unlocked, user page reads FFh.
module srl_access
  import srl_pkg::*;
#(
  parameter int TWC_CYCLES = (`SRL_TWC_US * 1000) / `SRL_CLK_SYS_NS,
  parameter logic [127:0] SERIAL_NUMBER = `SRL_SERIAL_DEFAULT
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic client_address_pin_2_i,
  input wire logic client_address_pin_1_i,
  input wire logic client_address_pin_0_i,
  input wire logic wp_i,
  output logic busy_o,
  output logic locked_o
);

  // Link domain: pin synchronisers and bus events.
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic [2:0] pins_q0;
  logic [2:0] pins_q1;
  logic scl_d;
  logic sda_d;
  logic [1:0] busy_q;
  logic [1:0] lock_q;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;

  // Link domain: byte engine.
  srl_link_st_e lk_st_r;
  logic [3:0] cnt_r;
  logic ack_ph_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic lock_mode_r;
  logic addr_ok_r;
  logic first_rd_r;
  logic host_ack_r;
  logic oe_r;
  logic stop_tgl_r;
  srl_req_s req_r;
  logic [`SRL_PAGE_BYTES-1:0] mask_r;
  logic [7:0] rd_data;
  logic stage_we;

  // System domain.
  logic [2:0] stop_q;
  logic [1:0] wp_q;
  logic stop_ev;
  srl_sys_st_e sy_st_r;
  logic [`SRL_PAGE_AW-1:0] idx_r;
  logic [23:0] tmr_r;
  logic lock_pend_r;
  logic [`SRL_PAGE_BYTES-1:0] mask_s_r;
  logic cp_v_r;
  logic [`SRL_PAGE_AW-1:0] cp_a_r;
  logic [7:0] stage_q;
  logic busy_r;
  // The lock stands for a nonvolatile bit, so no reset may clear it.
  logic locked_r = 1'b0;

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pins_q0 <= 3'h0;
      pins_q1 <= 3'h0;
      busy_q <= 2'h0;
      lock_q <= 2'h0;
    end else begin
      scl_q <= {scl_q[0], scl_i};
      sda_q <= {sda_q[0], sda_i};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
      pins_q0 <= {client_address_pin_2_i, client_address_pin_1_i, client_address_pin_0_i};
      pins_q1 <= pins_q0;
      busy_q <= {busy_q[0], busy_r};
      lock_q <= {lock_q[0], locked_r};
    end
  end

  // Start and stop are data edges while the clock line stays high.
  assign start_w = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  assign stop_w = scl_q[1] & scl_d & ~sda_d & sda_q[1];
  assign rise_w = scl_q[1] & ~scl_d;
  assign fall_w = ~scl_q[1] & scl_d;

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk_st_r <= SRL_LK_IDLE;
      cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      lock_mode_r <= 1'b0;
      addr_ok_r <= 1'b0;
      first_rd_r <= 1'b0;
      host_ack_r <= 1'b0;
      oe_r <= 1'b0;
      stop_tgl_r <= 1'b0;
      req_r <= '0;
      mask_r <= '0;
    end else if (stop_w) begin
      lk_st_r <= SRL_LK_IDLE;
      ack_ph_r <= 1'b0;
      oe_r <= 1'b0;
      addr_ok_r <= 1'b0;
      stop_tgl_r <= ~stop_tgl_r;
    end else if (start_w) begin
      lk_st_r <= SRL_LK_DEV;
      cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      oe_r <= 1'b0;
      lock_mode_r <= 1'b0;
      req_r <= '0;
      mask_r <= '0;
    end else if (rise_w && lk_st_r != SRL_LK_IDLE) begin
      if (!ack_ph_r) begin
        if (cnt_r != `SRL_BIT_LAST) begin
          rx_r <= {rx_r[6:0], sda_q[1]};
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        host_ack_r <= ~sda_q[1];
      end
    end else if (fall_w && lk_st_r != SRL_LK_IDLE) begin
      if (ack_ph_r) begin
        ack_ph_r <= 1'b0;
        cnt_r <= 4'h0;
        if (lk_st_r == SRL_LK_RDATA) begin
          if (first_rd_r || host_ack_r) begin
            tx_r <= rd_data;
            oe_r <= ~rd_data[7];
            ptr_r <= ptr_r + 8'h01;
            first_rd_r <= 1'b0;
          end else begin
            lk_st_r <= SRL_LK_IDLE;
            oe_r <= 1'b0;
          end
        end else begin
          oe_r <= 1'b0;
        end
      end else if (lk_st_r == SRL_LK_RDATA) begin
        if (cnt_r == `SRL_BIT_LAST) begin
          oe_r <= 1'b0;
          ack_ph_r <= 1'b1;
        end else begin
          oe_r <= ~tx_r[6];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end else if (cnt_r == `SRL_BIT_LAST) begin
        ack_ph_r <= 1'b1;
        unique case (lk_st_r)
          SRL_LK_DEV: begin
            if (rx_r[7:4] == `SRL_DEV_TYPE && rx_r[3:1] == pins_q1 && !busy_q[1] &&
                (!rx_r[0] || addr_ok_r)) begin
              oe_r <= 1'b1;
              if (rx_r[0]) begin
                lk_st_r <= SRL_LK_RDATA;
                first_rd_r <= 1'b1;
              end else begin
                lk_st_r <= SRL_LK_ADDR_HI;
              end
            end else begin
              lk_st_r <= SRL_LK_IDLE;
            end
          end
          SRL_LK_ADDR_HI: begin
            if (!rx_r[7] && rx_r[3:0] == `SRL_LOCK_NIB) begin
              lock_mode_r <= 1'b1;
              if (!lock_q[1]) begin
                oe_r <= 1'b1;
                lk_st_r <= SRL_LK_ADDR_LO;
              end else begin
                lk_st_r <= SRL_LK_IDLE;
              end
            end else if (!rx_r[7] && rx_r[3:2] == `SRL_REGION_NIB) begin
              oe_r <= 1'b1;
              lk_st_r <= SRL_LK_ADDR_LO;
            end else begin
              lk_st_r <= SRL_LK_IDLE;
            end
          end
          SRL_LK_ADDR_LO: begin
            if (lock_mode_r && lock_q[1]) begin
              lk_st_r <= SRL_LK_IDLE;
            end else begin
              oe_r <= 1'b1;
              lk_st_r <= SRL_LK_WDATA;
              if (!lock_mode_r) begin
                ptr_r <= rx_r;
                addr_ok_r <= 1'b1;
                req_r.hi <= rx_r[7];
              end
            end
          end
          SRL_LK_WDATA: begin
            if (lock_mode_r) begin
              if (!lock_q[1]) begin
                oe_r <= 1'b1;
                req_r.lock <= 1'b1;
              end else begin
                lk_st_r <= SRL_LK_IDLE;
              end
            end else begin
              oe_r <= 1'b1;
              req_r.wr <= 1'b1;
              mask_r[ptr_r[`SRL_PAGE_AW-1:0]] <= 1'b1;
              ptr_r[`SRL_PAGE_AW-1:0] <= ptr_r[`SRL_PAGE_AW-1:0] + 7'h01;
            end
          end
          SRL_LK_IDLE, SRL_LK_RDATA: begin
          end
        endcase
      end
    end
  end

  assign stage_we = fall_w && !ack_ph_r && !stop_w && !start_w && cnt_r == `SRL_BIT_LAST &&
                    lk_st_r == SRL_LK_WDATA && !lock_mode_r;

  // Page data waits here until the stop; the link is quiet while it is copied.
  srl_dpram #(
    .AW(`SRL_PAGE_AW),
    .INIT_SERIAL(SERIAL_NUMBER)
  ) u_stage (
    .wr_clk_i(clk_link_i),
    .wr_en_i(stage_we),
    .wr_addr_i(ptr_r[`SRL_PAGE_AW-1:0]),
    .wr_data_i(rx_r),
    .rd_clk_i(clk_sys_i),
    .rd_addr_i(idx_r),
    .rd_data_o(stage_q)
  );

  srl_dpram #(
    .AW(`SRL_REGION_AW),
    .INIT_SERIAL(SERIAL_NUMBER)
  ) u_region (
    .wr_clk_i(clk_sys_i),
    .wr_en_i(cp_v_r),
    .wr_addr_i({1'b1, cp_a_r}),
    .wr_data_i(stage_q),
    .rd_clk_i(clk_link_i),
    .rd_addr_i(ptr_r),
    .rd_data_o(rd_data)
  );

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= oe_r;
    end
  end

  // System domain: stop event and protect pin crossing.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_q <= 3'h0;
      wp_q <= 2'h0;
    end else begin
      stop_q <= {stop_q[1:0], stop_tgl_r};
      wp_q <= {wp_q[0], wp_i};
    end
  end

  assign stop_ev = stop_q[2] ^ stop_q[1];

  // Request fields are read only after the stop toggle lands; they hold still until
  // the next start, and the busy answer keeps that start from writing the stage.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy_st_r <= SRL_SY_IDLE;
      idx_r <= 7'h00;
      tmr_r <= 24'h000000;
      lock_pend_r <= 1'b0;
      mask_s_r <= '0;
      busy_r <= 1'b0;
    end else begin
      unique case (sy_st_r)
        SRL_SY_IDLE: begin
          idx_r <= 7'h00;
          tmr_r <= 24'h000000;
          if (stop_ev) begin
            if (req_r.lock && !locked_r) begin
              lock_pend_r <= 1'b1;
              busy_r <= 1'b1;
              sy_st_r <= SRL_SY_WAIT;
            end else if (req_r.wr && req_r.hi && !wp_q[1] && !locked_r) begin
              mask_s_r <= mask_r;
              busy_r <= 1'b1;
              sy_st_r <= SRL_SY_COPY;
            end
          end
        end
        SRL_SY_COPY: begin
          idx_r <= idx_r + 7'h01;
          if (idx_r == 7'h7f) begin
            sy_st_r <= SRL_SY_WAIT;
          end
        end
        SRL_SY_WAIT: begin
          tmr_r <= tmr_r + 24'h000001;
          if (tmr_r == 24'(TWC_CYCLES - 1)) begin
            sy_st_r <= SRL_SY_IDLE;
            busy_r <= 1'b0;
            lock_pend_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Stage read data lags its index by one cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_v_r <= 1'b0;
      cp_a_r <= 7'h00;
    end else begin
      cp_v_r <= (sy_st_r == SRL_SY_COPY) && mask_s_r[idx_r];
      cp_a_r <= idx_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sy_st_r == SRL_SY_WAIT && lock_pend_r && tmr_r == 24'(TWC_CYCLES - 1)) begin
      locked_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      busy_o <= busy_r;
      locked_o <= locked_r;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/srl_cfg.svh
// Constants of the security region access block.
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

`define SRL_DEV_TYPE 4'hb
`define SRL_LOCK_NIB 4'h6
`define SRL_REGION_NIB 2'b10
`define SRL_REGION_AW 8
`define SRL_PAGE_AW 7
`define SRL_PAGE_BYTES 128
`define SRL_SERIAL_BYTES 16
`define SRL_ERASED 8'hff
`define SRL_BIT_LAST 4'h8
`define SRL_CLK_SYS_NS 40
`define SRL_TWC_US 1000
`define SRL_SERIAL_DEFAULT 128'h0123456789abcdef0f1e2d3c4b5a6978

`endif

// ===== rtl/srl_pkg.sv
// Types shared by the security region access block.
`default_nettype none

package srl_pkg;

  typedef enum logic [2:0] {
    SRL_LK_IDLE,
    SRL_LK_DEV,
    SRL_LK_ADDR_HI,
    SRL_LK_ADDR_LO,
    SRL_LK_WDATA,
    SRL_LK_RDATA
  } srl_link_st_e;

  typedef enum logic [1:0] {
    SRL_SY_IDLE,
    SRL_SY_COPY,
    SRL_SY_WAIT
  } srl_sys_st_e;

  typedef struct packed {
    logic lock;
    logic wr;
    logic hi;
  } srl_req_s;

endpackage

`default_nettype wire

// ===== rtl/srl_dpram.sv
// Two-clock byte memory with registered read data.
`default_nettype none
`include "srl_cfg.svh"

module srl_dpram #(
  parameter int AW = 8,
  parameter logic [127:0] INIT_SERIAL = `SRL_SERIAL_DEFAULT
) (
  input wire logic wr_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem [2**AW];

  // Power-up image stands in for factory content; the rest reads erased.
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      if (i < `SRL_SERIAL_BYTES) begin
        mem[i] = INIT_SERIAL[127-8*i -: 8];
      end else begin
        mem[i] = `SRL_ERASED;
      end
    end
  end

  // A plain always, because the power-up image above writes the same array.
  always @(posedge wr_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge rd_clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

`default_nettype wire

// ===== tb/srl_access_asserts.sv
// Port assertions for the security region access block.
`default_nettype none

module srl_access_asserts #(
  parameter int TWC_CYCLES = 25000
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic client_address_pin_2_i,
  input wire logic client_address_pin_1_i,
  input wire logic client_address_pin_0_i,
  input wire logic wp_i,
  input wire logic busy_o,
  input wire logic locked_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busy_len_r;

  // A cycle counter, because the write cycle is far longer than any repetition may be.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_len_r <= 16'h0;
    end else begin
      busy_len_r <= busy_o ? busy_len_r + 16'h1 : 16'h0;
    end
  end

  a_sda_low_only: assert property (
    @(posedge clk_link_i) disable iff (!rst_n_i) sda_o == 1'b0)
    else $error("sda driven high");
  a_oe_rise_lo: assert property (
    @(posedge clk_link_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("sda pulled while scl high");
  a_stop_release: assert property (
    @(posedge clk_link_i) disable iff (!rst_n_i) scl_i && $rose(sda_i) |-> !sda_oe_o [*8])
    else $error("sda pulled after stop");
  a_lock_sticky: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) locked_o |=> locked_o)
    else $error("lock cleared");
  a_lock_at_end: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(locked_o) |->
      $past(busy_o, 1) || $past(busy_o, 2) || $past(busy_o, 3) || !$past(rst_n_i, 3))
    else $error("lock without cycle");
  a_locked_no_cycle: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) locked_o |=> !$rose(busy_o))
    else $error("cycle while locked");
  a_busy_end: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) busy_o |-> busy_len_r <= TWC_CYCLES + 128)
    else $error("cycle never ends");
  a_busy_len: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) $fell(busy_o) |->
      (busy_len_r >= TWC_CYCLES && busy_len_r <= TWC_CYCLES + 1) ||
      (busy_len_r >= TWC_CYCLES + 128 && busy_len_r <= TWC_CYCLES + 129))
    else $error("cycle length wrong");

  c_cycle: cover property (@(posedge clk_sys_i) $rose(busy_o));
  c_lock: cover property (@(posedge clk_sys_i) $rose(locked_o));
  c_ack: cover property (@(posedge clk_link_i) $rose(sda_oe_o));
endmodule

`default_nettype wire

// ===== tb/srl_host.sv
// Two-wire bus host model driving the serial pins of the block.
`default_nettype none

module srl_host (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  input wire logic dev_o,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_r = 1'b1;
  logic clk_r = 1'b1;

  assign sda_o = drv_r & ~(dev_oe_i & ~dev_o);
  assign scl_o = clk_r;

  task automatic q(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data moves only mid-low, so no edge can be mistaken for Start or Stop.
  task automatic bit_x(input logic b, output logic r);
    q(3);
    drv_r <= b;
    q(3);
    clk_r <= 1'b1;
    q(6);
    r = sda_o;
    clk_r <= 1'b0;
  endtask

  task automatic start();
    q(3);
    drv_r <= 1'b1;
    q(3);
    clk_r <= 1'b1;
    q(6);
    drv_r <= 1'b0;
    q(6);
    clk_r <= 1'b0;
  endtask

  task automatic stop();
    q(3);
    drv_r <= 1'b0;
    q(3);
    clk_r <= 1'b1;
    q(6);
    drv_r <= 1'b1;
    q(6);
  endtask

  task automatic tx(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nak);
  endtask

  task automatic rx(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nak, r);
  endtask
endmodule

`default_nettype wire

// ===== tb/tb_srl_access.sv
// Self-checking testbench of the security region access block.
`default_nettype none

module tb_srl_access;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] SER = 128'hc3a5_1122_3344_5566_7788_99aa_bbcc_ddee;
  localparam logic [7:0] DEV = 8'hba;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_i = 1'b0;
  wire logic scl;
  wire logic sda;
  logic sda_o, sda_oe, busy, locked;
  logic [7:0] img [256];
  int miscompares = 0;
  int n_checks = 0;

  always #20 clk_sys_i = ~clk_sys_i;
  always #24 clk_link_i = ~clk_link_i;

  srl_access #(.TWC_CYCLES(200), .SERIAL_NUMBER(SER)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .client_address_pin_2_i(1'b1),
    .client_address_pin_1_i(1'b0), .client_address_pin_0_i(1'b1), .wp_i(wp_i),
    .busy_o(busy), .locked_o(locked));
  srl_host host (.clk_i(clk_sys_i), .dev_oe_i(sda_oe), .dev_o(sda_o), .scl_o(scl), .sda_o(sda));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [15:0] wa, input int nw, input int nd, input logic [7:0] d,
      output logic nk);
    logic a;
    host.start();
    host.tx(DEV, nk);
    for (int i = 0; i < nw + nd; i++) begin
      host.tx(i == 0 ? wa[15:8] : i == 1 ? wa[7:0] : d + 8'(i - 2), a);
      nk = nk | a;
    end
    host.stop();
  endtask

  task automatic rd(input logic [15:0] wa, input int n);
    logic a;
    logic [7:0] q;
    host.start();
    host.tx(DEV, a);
    host.tx(wa[15:8], a);
    host.tx(wa[7:0], a);
    host.start();
    host.tx(DEV | 8'h1, a);
    check("read address ack", a, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.rx(i == n - 1, q);
      check("region byte", q, img[8'(wa[7:0] + i)]);
    end
    host.stop();
  endtask

  // Any cycle starts within a few cycles of Stop; a hung cycle ends the run.
  task automatic cycle(input string what, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_sys_i);
      seen = seen | busy;
    end
    check(what, seen, exp);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys_i);
    if (busy !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic s_read();
    check("delivered lock", locked, 1'b0);
    rd(16'h0800, 257);
  endtask

  task automatic s_refuse();
    logic a;
    logic [7:0] bad [3] = '{8'haa, 8'hb8, 8'hbb};
    foreach (bad[i]) begin
      host.start();
      host.tx(bad[i], a);
      host.stop();
      check("bad device byte", a, 1'b1);
    end
    wr(16'h8800, 1, 0, 8'h00, a);
    check("a15 high", a, 1'b1);
    wr(16'h0c00, 1, 0, 8'h00, a);
    check("a10 high", a, 1'b1);
  endtask

  task automatic s_write();
    logic a;
    wr(16'h08ff, 2, 2, 8'h5a, a);
    check("page write ack", a, 1'b0);
    host.start();
    host.tx(DEV, a);
    host.stop();
    check("busy poll", a, 1'b1);
    cycle("page write cycle", 1'b1);
    img[255] = 8'h5a;
    img[128] = 8'h5b;
    rd(16'h08ff, 2);
    rd(16'h087f, 2);
    wr(16'h0803, 2, 1, 8'h00, a);
    cycle("lower page write", 1'b0);
    @(posedge clk_sys_i);
    wp_i <= 1'b1;
    wr(16'h0890, 2, 1, 8'h11, a);
    cycle("protected write", 1'b0);
    rd(16'h0802, 2);
    rd(16'h0890, 1);
  endtask

  task automatic s_lock();
    logic a;
    wr(16'h0600, 1, 0, 8'h00, a);
    check("status unlocked", a, 1'b0);
    wr(16'h0600, 2, 0, 8'h00, a);
    cycle("short lock", 1'b0);
    check("short lock state", locked, 1'b0);
    wr(16'h0655, 2, 1, 8'h3c, a);
    check("lock acks", a, 1'b0);
    cycle("lock cycle", 1'b1);
    check("locked", locked, 1'b1);
    wr(16'h0600, 1, 0, 8'h00, a);
    check("status locked", a, 1'b1);
    wr(16'h0600, 2, 1, 8'h00, a);
    check("relock refused", a, 1'b1);
    @(posedge clk_sys_i);
    wp_i <= 1'b0;
    wr(16'h0881, 2, 1, 8'h77, a);
    cycle("locked write", 1'b0);
    rd(16'h0881, 1);
    check("lock kept", locked, 1'b1);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check("lock after reset", locked, 1'b1);
    wr(16'h0600, 1, 0, 8'h00, a);
    check("status after reset", a, 1'b1);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) img[i] = i < 16 ? SER[127 - 8 * i -: 8] : 8'hff;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    s_read();
    s_refuse();
    s_write();
    s_lock();
    give_verdict();
  end
endmodule

bind srl_access srl_access_asserts #(.TWC_CYCLES(TWC_CYCLES)) chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .client_address_pin_2_i(client_address_pin_2_i),
  .client_address_pin_1_i(client_address_pin_1_i),
  .client_address_pin_0_i(client_address_pin_0_i), .wp_i(wp_i), .busy_o(busy_o),
  .locked_o(locked_o));

`default_nettype wire
